// ### rtl/dsst_ctrl.sv
// AXI4-Lite control register block for display sync timing
//
// Overview of operation
// - Vertical sweep start is 11 bits: low byte plus shared register bits 0-2.
// - Vertical sweep stop is low byte plus shared register bits from bit 3.
// - Readout window vertical start/stop are 10 bits; high bits 0-1 and 2-3.
// - Readout window horizontal start/stop are 10 bits; high bits 0-1 and 2-3.
// - Display field count is bits 0-3, holding the number of fields minus one.
// - Aux signal horizontal start/stop are 10 bits; high bits 0-1 and 2-3.
// - Aux signal vertical start/stop are 10 bits; high bits 4-5 and 6-7.
// - Sync mode bit 0 set suppresses internal vertical reset; clear enables it.
// - Sync mode bit 1 set enables direct vertical frame synchronisation.
// - Sync mode bit 2 selects field-repeat raster sync instead of standard.
// - Sync mode bit 4 switches the timing generator mode on.
// - Sync mode bit 5 directly drives the input-enable output pin level.
// - Sync mode bit 6 selects smooth-lock synchronisation.
// - Horizontal sweep start/stop are 8-bit registers with 4-pixel steps.
// - Display field length is 11 bits; low byte in its own register.
// - Field length top 3 bits come from next register bits 0-2.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "dsst_defines.svh"

module dsst_ctrl
  import dsst_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic [2:0]           s_axi_awprot_i,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  output logic [1:0]                s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic [2:0]           s_axi_arprot_i,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  // Deflection pulse positions
  output dsst_win11_type            vert_sweep_pulse_o,
  output logic [9:0]                horiz_sweep_pulse_start_o,
  output logic [9:0]                horiz_sweep_pulse_stop_o,
  // Readout and auxiliary windows
  output dsst_win10_type            readout_win_vert_o,
  output dsst_win10_type            readout_win_horiz_o,
  output dsst_win10_type            aux_signal_horiz_o,
  output dsst_win10_type            aux_signal_vert_o,
  // Field setup
  output logic [3:0]                display_field_count_o,
  output logic [10:0]               display_field_length_o,
  // Synchronisation modes and input-enable pin
  output dsst_sync_mode_type        sync_mode_o,
  output logic                      input_enable_pin_o
);

  // ============================================================
  // Elaboration checks
  if (ADDR_W < `DSST_IDX_W + 2) begin
    $error("ADDR_W too small for the register map");
  end

  localparam int IDX_HI = `DSST_IDX_W + 1;

  // ============================================================
  // Map helpers
  // Unmapped indices return an empty mask, which doubles as the decode.
  function automatic logic [7:0] reg_mask(input logic [9:0] idx);
    logic [7:0] m;
    m = `DSST_MASK_NONE;
    case (idx)
      `DSST_VSWEEP_START_LO: m = `DSST_MASK_FULL;
      `DSST_VSWEEP_STOP_LO:  m = `DSST_MASK_FULL;
      `DSST_RWIN_VSTART_LO:  m = `DSST_MASK_FULL;
      `DSST_RWIN_VSTOP_LO:   m = `DSST_MASK_FULL;
      `DSST_FIELD_COUNT:     m = `DSST_MASK_NIBBLE;
      `DSST_RWIN_VERT_HI:    m = `DSST_MASK_NIBBLE;
      `DSST_VSWEEP_HI:       m = `DSST_MASK_VSWEEP_HI;
      `DSST_AUX_HSTART_LO:   m = `DSST_MASK_FULL;
      `DSST_AUX_HSTOP_LO:    m = `DSST_MASK_FULL;
      `DSST_SYNC_MODE:       m = `DSST_MASK_SYNC_MODE;
      `DSST_AUX_VSTART_LO:   m = `DSST_MASK_FULL;
      `DSST_AUX_VSTOP_LO:    m = `DSST_MASK_FULL;
      `DSST_AUX_HI:          m = `DSST_MASK_FULL;
      `DSST_HSWEEP_START:    m = `DSST_MASK_FULL;
      `DSST_HSWEEP_STOP:     m = `DSST_MASK_FULL;
      `DSST_RWIN_HSTART_LO:  m = `DSST_MASK_FULL;
      `DSST_RWIN_HSTOP_LO:   m = `DSST_MASK_FULL;
      `DSST_RWIN_HORIZ_HI:   m = `DSST_MASK_NIBBLE;
      `DSST_FIELD_LEN_LO:    m = `DSST_MASK_FULL;
      `DSST_FIELD_LEN_HI:    m = `DSST_MASK_FLEN_HI;
      default:               m = `DSST_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic [4:0] slot_of(input logic [9:0] idx);
    logic [9:0] d;
    d = idx - `DSST_IDX_BASE;
    return d[4:0];
  endfunction

  function automatic logic [7:0] rd_reg(input dsst_state_type s, input logic [9:0] idx);
    return s.regs[slot_of(idx)];
  endfunction

  // ============================================================
  // State
  dsst_state_type q_r;
  dsst_state_type q_nxt;

  logic [9:0] ar_idx;
  logic       ar_hi_bad;
  logic [9:0] aw_idx_in;
  logic       aw_hi_bad_in;

  assign ar_idx       = s_axi_araddr_i[IDX_HI:2];
  assign ar_hi_bad    = |(s_axi_araddr_i >> (IDX_HI + 1));
  assign aw_idx_in    = s_axi_awaddr_i[IDX_HI:2];
  assign aw_hi_bad_in = |(s_axi_awaddr_i >> (IDX_HI + 1));

  // ============================================================
  // Next-state logic
  always_comb begin
    logic       do_write;
    logic       mapped;
    logic       is_status;
    logic [7:0] m;
    logic       err_set;
    logic       err_clr;
    do_write  = 1'b0;
    mapped    = 1'b0;
    is_status = 1'b0;
    m         = `DSST_MASK_NONE;
    err_set   = 1'b0;
    err_clr   = 1'b0;
    q_nxt     = q_r;

    // Address and data are taken in either order and held until both are in
    if (s_axi_awvalid_i && q_r.awready) begin
      q_nxt.aw_held   = 1'b1;
      q_nxt.aw_idx    = aw_idx_in;
      q_nxt.aw_hi_bad = aw_hi_bad_in;
    end
    if (s_axi_wvalid_i && q_r.wready) begin
      q_nxt.w_held = 1'b1;
      q_nxt.w_data = s_axi_wdata_i;
      q_nxt.w_strb = s_axi_wstrb_i;
    end

    case (q_r.wst)
      DSST_WS_COLLECT: begin
        if (q_r.aw_held && q_r.w_held) begin
          do_write      = 1'b1;
          q_nxt.aw_held = 1'b0;
          q_nxt.w_held  = 1'b0;
          q_nxt.bvalid  = 1'b1;
          q_nxt.wst     = DSST_WS_RESP;
        end
      end
      DSST_WS_RESP: begin
        if (s_axi_bready_i) begin
          q_nxt.bvalid = 1'b0;
          q_nxt.wst    = DSST_WS_COLLECT;
        end
      end
      default: begin
        q_nxt.wst = DSST_WS_COLLECT;
      end
    endcase

    // Register write; reserved bits are masked off so they read back as zero
    if (do_write) begin
      m         = reg_mask(q_r.aw_idx);
      is_status = (q_r.aw_idx == `DSST_STATUS) && !q_r.aw_hi_bad;
      mapped    = ((m != `DSST_MASK_NONE) && !q_r.aw_hi_bad) || is_status;
      q_nxt.bresp = mapped ? `DSST_RESP_OKAY : `DSST_RESP_SLVERR;
      if (!mapped) begin
        err_set = 1'b1;
      end else if (is_status) begin
        err_clr = q_r.w_strb[`DSST_ST_ERR_LANE] & q_r.w_data[`DSST_ST_ERR_BIT];
      end else begin
        q_nxt.wr_count = q_r.wr_count + `DSST_CNT_STEP;
        if (q_r.w_strb[0]) begin
          q_nxt.regs[slot_of(q_r.aw_idx)] = q_r.w_data[7:0] & m;
        end
      end
    end

    // Read channel: one read at a time, answered one cycle after acceptance
    if (s_axi_arvalid_i && q_r.arready) begin
      m           = reg_mask(ar_idx);
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = `DSST_RESP_OKAY;
      q_nxt.rdata  = `DSST_DATA_ZERO;
      if (ar_hi_bad) begin
        q_nxt.rresp = `DSST_RESP_SLVERR;
        err_set     = 1'b1;
      end else if (ar_idx == `DSST_STATUS) begin
        q_nxt.rdata[15:0]              = q_r.wr_count;
        q_nxt.rdata[`DSST_ST_ERR_BIT]  = q_r.err_flag;
      end else if (m != `DSST_MASK_NONE) begin
        q_nxt.rdata[7:0] = rd_reg(q_r, ar_idx);
      end else begin
        q_nxt.rresp = `DSST_RESP_SLVERR;
        err_set     = 1'b1;
      end
    end else if (q_r.rvalid && s_axi_rready_i) begin
      q_nxt.rvalid = 1'b0;
    end

    // Sticky error flag: a new error in the clearing cycle wins
    q_nxt.err_flag = (q_r.err_flag & ~err_clr) | err_set;

    // Ready flags look ahead so they are plain flops at the ports
    q_nxt.awready = !q_nxt.aw_held && (q_nxt.wst == DSST_WS_COLLECT);
    q_nxt.wready  = !q_nxt.w_held && (q_nxt.wst == DSST_WS_COLLECT);
    q_nxt.arready = !q_nxt.rvalid;
  end

  // ============================================================
  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ============================================================
  // Bus outputs
  assign s_axi_awready_o = q_r.awready;
  assign s_axi_wready_o  = q_r.wready;
  assign s_axi_bvalid_o  = q_r.bvalid;
  assign s_axi_bresp_o   = q_r.bresp;
  assign s_axi_arready_o = q_r.arready;
  assign s_axi_rvalid_o  = q_r.rvalid;
  assign s_axi_rdata_o   = q_r.rdata;
  assign s_axi_rresp_o   = q_r.rresp;

  // ============================================================
  // Field assembly: pure wiring of stored bits, no logic between flop and pin
  logic [7:0] r_vs_lo;
  logic [7:0] r_vp_lo;
  logic [7:0] r_vs_hi;
  logic [7:0] r_rv_hi;
  logic [7:0] r_rh_hi;
  logic [7:0] r_aux_hi;
  logic [7:0] r_mode;
  logic [7:0] r_fl_hi;
  logic [7:0] r_fcnt;

  assign r_vs_lo  = rd_reg(q_r, `DSST_VSWEEP_START_LO);
  assign r_vp_lo  = rd_reg(q_r, `DSST_VSWEEP_STOP_LO);
  assign r_vs_hi  = rd_reg(q_r, `DSST_VSWEEP_HI);
  assign r_rv_hi  = rd_reg(q_r, `DSST_RWIN_VERT_HI);
  assign r_rh_hi  = rd_reg(q_r, `DSST_RWIN_HORIZ_HI);
  assign r_aux_hi = rd_reg(q_r, `DSST_AUX_HI);
  assign r_mode   = rd_reg(q_r, `DSST_SYNC_MODE);
  assign r_fl_hi  = rd_reg(q_r, `DSST_FIELD_LEN_HI);
  assign r_fcnt   = rd_reg(q_r, `DSST_FIELD_COUNT);

  assign vert_sweep_pulse_o.start = {r_vs_hi[2:0], r_vs_lo};
  // Only two upper stop bits are stored; the top bit of the stop line is zero
  assign vert_sweep_pulse_o.stop  = {1'b0, r_vs_hi[4:3], r_vp_lo};

  assign readout_win_vert_o.start  = {r_rv_hi[1:0], rd_reg(q_r, `DSST_RWIN_VSTART_LO)};
  assign readout_win_vert_o.stop   = {r_rv_hi[3:2], rd_reg(q_r, `DSST_RWIN_VSTOP_LO)};
  assign readout_win_horiz_o.start = {r_rh_hi[1:0], rd_reg(q_r, `DSST_RWIN_HSTART_LO)};
  assign readout_win_horiz_o.stop  = {r_rh_hi[3:2], rd_reg(q_r, `DSST_RWIN_HSTOP_LO)};

  assign display_field_count_o = r_fcnt[3:0];

  assign aux_signal_horiz_o.start = {r_aux_hi[1:0], rd_reg(q_r, `DSST_AUX_HSTART_LO)};
  assign aux_signal_horiz_o.stop  = {r_aux_hi[3:2], rd_reg(q_r, `DSST_AUX_HSTOP_LO)};
  assign aux_signal_vert_o.start  = {r_aux_hi[5:4], rd_reg(q_r, `DSST_AUX_VSTART_LO)};
  assign aux_signal_vert_o.stop   = {r_aux_hi[7:6], rd_reg(q_r, `DSST_AUX_VSTOP_LO)};

  assign sync_mode_o.vert_reset_disable         = r_mode[`DSST_SM_VRES_DIS];
  assign sync_mode_o.direct_frame_sync          = r_mode[`DSST_SM_DIRECT];
  assign sync_mode_o.field_repeat_raster_select = r_mode[`DSST_SM_RASTER];
  assign sync_mode_o.generator_mode             = r_mode[`DSST_SM_GEN];
  assign sync_mode_o.input_enable_output_level  = r_mode[`DSST_SM_IE];
  assign sync_mode_o.smooth_lock                = r_mode[`DSST_SM_SMOOTH];
  assign input_enable_pin_o                     = r_mode[`DSST_SM_IE];

  // Pixel positions: one register step is four pixels
  assign horiz_sweep_pulse_start_o = {rd_reg(q_r, `DSST_HSWEEP_START), 2'b00};
  assign horiz_sweep_pulse_stop_o  = {rd_reg(q_r, `DSST_HSWEEP_STOP), 2'b00};

  assign display_field_length_o = {r_fl_hi[2:0], rd_reg(q_r, `DSST_FIELD_LEN_LO)};

endmodule

// ### rtl/dsst_defines.svh
// Register indices, field masks and positions for the display sync timing control block
`ifndef DSST_DEFINES_SVH
`define DSST_DEFINES_SVH

// ============================================================
// Index space: byte address is four times the index
`define DSST_IDX_W            10
`define DSST_SLOT_W           5
`define DSST_NREG             26
`define DSST_IDX_BASE         10'h222

// ============================================================
// Register indices
`define DSST_VSWEEP_START_LO  10'h222
`define DSST_VSWEEP_STOP_LO   10'h223
`define DSST_RWIN_VSTART_LO   10'h224
`define DSST_RWIN_VSTOP_LO    10'h225
`define DSST_FIELD_COUNT      10'h226
`define DSST_RWIN_VERT_HI     10'h227
`define DSST_VSWEEP_HI        10'h228
`define DSST_AUX_HSTART_LO    10'h229
`define DSST_AUX_HSTOP_LO     10'h22a
`define DSST_SYNC_MODE        10'h22b
`define DSST_AUX_VSTART_LO    10'h22c
`define DSST_AUX_VSTOP_LO     10'h22d
`define DSST_AUX_HI           10'h22e
`define DSST_HSWEEP_START     10'h230
`define DSST_HSWEEP_STOP      10'h231
`define DSST_RWIN_HSTART_LO   10'h234
`define DSST_RWIN_HSTOP_LO    10'h235
`define DSST_RWIN_HORIZ_HI    10'h238
`define DSST_FIELD_LEN_LO     10'h23a
`define DSST_FIELD_LEN_HI     10'h23b
`define DSST_STATUS           10'h240

// ============================================================
// Writable bit masks (reserved bits are not stored)
`define DSST_MASK_FULL        8'hff
`define DSST_MASK_NIBBLE      8'h0f
`define DSST_MASK_VSWEEP_HI   8'h1f
`define DSST_MASK_SYNC_MODE   8'h77
`define DSST_MASK_FLEN_HI     8'h07
`define DSST_MASK_NONE        8'h00

// ============================================================
// Field positions
`define DSST_SM_VRES_DIS      0
`define DSST_SM_DIRECT        1
`define DSST_SM_RASTER        2
`define DSST_SM_GEN           4
`define DSST_SM_IE            5
`define DSST_SM_SMOOTH        6
`define DSST_ST_ERR_BIT       16
`define DSST_ST_ERR_LANE      2

// ============================================================
// Bus responses and reset values
`define DSST_RESP_OKAY        2'b00
`define DSST_RESP_SLVERR      2'b10
`define DSST_REG_RESET        8'h00
`define DSST_CNT_RESET        16'h0000
`define DSST_CNT_STEP         16'h0001
`define DSST_DATA_ZERO        32'h0000_0000

`endif

// ### rtl/dsst_pkg.sv
// Types shared by the display sync timing control block
package dsst_pkg;

  // ============================================================
  // Window and mode carriers
  typedef struct packed {
    logic [9:0] start;
    logic [9:0] stop;
  } dsst_win10_type;

  typedef struct packed {
    logic [10:0] start;
    logic [10:0] stop;
  } dsst_win11_type;

  typedef struct packed {
    logic vert_reset_disable;
    logic direct_frame_sync;
    logic field_repeat_raster_select;
    logic generator_mode;
    logic input_enable_output_level;
    logic smooth_lock;
  } dsst_sync_mode_type;

  // ============================================================
  // Write channel state
  typedef enum logic [0:0] {
    DSST_WS_COLLECT = 1'b0,
    DSST_WS_RESP    = 1'b1
  } dsst_wstate_type;

  // ============================================================
  // Whole module state
  typedef struct packed {
    dsst_wstate_type  wst;
    logic             awready;
    logic             wready;
    logic             aw_held;
    logic             w_held;
    logic [9:0]       aw_idx;
    logic             aw_hi_bad;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             err_flag;
    logic [15:0]      wr_count;
    logic [25:0][7:0] regs;
  } dsst_state_type;

endpackage

// ### sim/dsst_ctrl_monitor.sv
// Port checker for the display sync timing control block
`timescale 1ns/1ns
module dsst_ctrl_monitor
  import dsst_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic               mclk_i,
  input wire logic               rst_i,
  // Bus handshakes
  input wire logic               s_axi_awvalid_i,
  input wire logic               s_axi_awready_o,
  input wire logic               s_axi_wvalid_i,
  input wire logic               s_axi_wready_o,
  input wire logic               s_axi_bvalid_o,
  input wire logic               s_axi_bready_i,
  input wire logic [1:0]         s_axi_bresp_o,
  input wire logic               s_axi_arvalid_i,
  input wire logic               s_axi_arready_o,
  input wire logic [ADDR_W-1:0]  s_axi_araddr_i,
  input wire logic               s_axi_rvalid_o,
  input wire logic               s_axi_rready_i,
  input wire logic [31:0]        s_axi_rdata_o,
  input wire logic [1:0]         s_axi_rresp_o,
  // Configuration outputs
  input wire dsst_win11_type     vert_sweep_pulse_o,
  input wire logic [9:0]         horiz_sweep_pulse_start_o,
  input wire logic [9:0]         horiz_sweep_pulse_stop_o,
  input wire dsst_sync_mode_type sync_mode_o,
  input wire logic               input_enable_pin_o
);
  // ============================================================
  // Write steps
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_resp_up;
    ##2 s_axi_bvalid_o;
  endsequence

  // ============================================================
  // Bus behaviour
  a_wr_answer:
    assert property (s_wr_take |-> s_resp_up) else $error("write response late");
  a_bresp_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
      && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_wr_blocked:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken during response");
  a_rd_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data late");
  a_rdata_hold:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_rd_blocked:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken early");
  a_rd_unmapped:
    assert property (s_axi_arvalid_i && s_axi_arready_o && (|s_axi_araddr_i[ADDR_W-1:12])
      |=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0000_0000)
      else $error("unmapped read not refused");
  // Config only moves on the edge that raises the write response
  a_cfg_quiet:
    assert property (!$rose(s_axi_bvalid_o) |-> $stable(sync_mode_o)
      && $stable(vert_sweep_pulse_o) && $stable(horiz_sweep_pulse_start_o))
      else $error("config changed without a write");

  // ============================================================
  // Field mapping
  a_ie_mirror:
    assert property (input_enable_pin_o == sync_mode_o.input_enable_output_level)
      else $error("input enable pin differs from mode bit");
  a_hsweep_step:
    assert property (horiz_sweep_pulse_start_o[1:0] == 2'b00
      && horiz_sweep_pulse_stop_o[1:0] == 2'b00) else $error("sweep not in 4 pixel steps");
  a_vstop_top:
    assert property (vert_sweep_pulse_o.stop[10] == 1'b0) else $error("sweep stop bit 10 set");
endmodule

bind dsst_ctrl dsst_ctrl_monitor #(.ADDR_W(ADDR_W)) dsst_ctrl_monitor_inst (
  .mclk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
  .vert_sweep_pulse_o, .horiz_sweep_pulse_start_o, .horiz_sweep_pulse_stop_o,
  .sync_mode_o, .input_enable_pin_o
);

// ### sim/dsst_ctrl_tb.sv
// Testbench for the display sync timing control block
`timescale 1ns/1ns
`include "dsst_defines.svh"
module dsst_ctrl_tb
  import dsst_pkg::*;
  ;
  logic mclk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, input_enable_pin_o;
  logic [15:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, display_field_count_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [9:0]  horiz_sweep_pulse_start_o, horiz_sweep_pulse_stop_o;
  logic [10:0] display_field_length_o;
  logic [4:0]  fields_total;
  logic        vert_reset_active;
  dsst_win11_type     vert_sweep_pulse_o;
  dsst_win10_type     readout_win_vert_o, readout_win_horiz_o;
  dsst_win10_type     aux_signal_horiz_o, aux_signal_vert_o;
  dsst_sync_mode_type sync_mode_o;
  int bad_count, samples_checked;

  dsst_ctrl dsst_ctrl_inst (
    .mclk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
    .s_axi_arprot_i(3'h0), .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
    .vert_sweep_pulse_o, .horiz_sweep_pulse_start_o, .horiz_sweep_pulse_stop_o,
    .readout_win_vert_o, .readout_win_horiz_o, .aux_signal_horiz_o, .aux_signal_vert_o,
    .display_field_count_o, .display_field_length_o, .sync_mode_o, .input_enable_pin_o);
  dsst_display_sink dsst_display_sink_inst (.field_count_i(display_field_count_o),
    .mode_i(sync_mode_o), .fields_total_o(fields_total), .vert_reset_active_o(vert_reset_active));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ============================================================
  // Shared tasks
  function automatic logic [15:0] ba(input logic [9:0] i);
    return {4'h0, i, 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic stall();
    bad_count++;
    $display("mismatch bus_answer expected response seen none");
    give_verdict();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er = `DSST_RESP_OKAY);
    int n;
    logic ha, hw, hb, bv;
    logic [1:0] rs;
    n = 0;
    hb = 1'b0;
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_wstrb_i <= 4'hf;
    s_axi_wvalid_i <= 1'b1;
    while (!hb) begin
      @(negedge mclk_i);
      ha = s_axi_awvalid_i && s_axi_awready_o;
      hw = s_axi_wvalid_i && s_axi_wready_o;
      hb = s_axi_bvalid_o && s_axi_bready_i;
      bv = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      @(posedge mclk_i);
      if (ha) s_axi_awvalid_i <= 1'b0;
      if (hw) s_axi_wvalid_i <= 1'b0;
      s_axi_bready_i <= bv && !hb;
      n++;
      if (n > 60) stall();
    end
    chk("bresp", 32'(rs), 32'(er));
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er = `DSST_RESP_OKAY);
    int n;
    logic ha, hr, rv;
    logic [31:0] dv;
    logic [1:0] rs;
    n = 0;
    hr = 1'b0;
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    while (!hr) begin
      @(negedge mclk_i);
      ha = s_axi_arvalid_i && s_axi_arready_o;
      hr = s_axi_rvalid_o && s_axi_rready_i;
      rv = s_axi_rvalid_o;
      dv = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      @(posedge mclk_i);
      if (ha) s_axi_arvalid_i <= 1'b0;
      s_axi_rready_i <= rv && !hr;
      n++;
      if (n > 60) stall();
    end
    chk("rdata", dv, ed);
    chk("rresp", 32'(rs), 32'(er));
  endtask
  task automatic do_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // ============================================================
  // Scenarios (software keeps reserved bits at zero throughout)
  task automatic t_reset();
    @(negedge mclk_i);
    chk("vsweep", 32'(vert_sweep_pulse_o), `DSST_DATA_ZERO);
    chk("mode", 32'(sync_mode_o), `DSST_DATA_ZERO);
    chk("flen", 32'(display_field_length_o), `DSST_DATA_ZERO);
    rd(ba(`DSST_SYNC_MODE), `DSST_DATA_ZERO);
    $display("test reset done");
  endtask
  task automatic t_vert();
    wr(ba(`DSST_VSWEEP_START_LO), 8'ha5);
    wr(ba(`DSST_VSWEEP_STOP_LO), 8'h3c);
    wr(ba(`DSST_VSWEEP_HI), 8'h1d);
    chk("vstart", 32'(vert_sweep_pulse_o.start), 32'h0000_05a5);
    chk("vstop", 32'(vert_sweep_pulse_o.stop), 32'h0000_033c);
    $display("test vertical sweep done");
  endtask
  task automatic t_win();
    wr(ba(`DSST_RWIN_VSTART_LO), 8'h11);
    wr(ba(`DSST_RWIN_VSTOP_LO), 8'h22);
    wr(ba(`DSST_RWIN_VERT_HI), 8'h0e);
    wr(ba(`DSST_RWIN_HSTART_LO), 8'h33);
    wr(ba(`DSST_RWIN_HSTOP_LO), 8'h44);
    wr(ba(`DSST_RWIN_HORIZ_HI), 8'h09);
    wr(ba(`DSST_AUX_HSTART_LO), 8'h55);
    wr(ba(`DSST_AUX_HSTOP_LO), 8'h66);
    wr(ba(`DSST_AUX_VSTART_LO), 8'h77);
    wr(ba(`DSST_AUX_VSTOP_LO), 8'h88);
    wr(ba(`DSST_AUX_HI), 8'hb4);
    chk("rwin_v", 32'(readout_win_vert_o), {12'h000, 10'h211, 10'h322});
    chk("rwin_h", 32'(readout_win_horiz_o), {12'h000, 10'h133, 10'h244});
    chk("aux_h", 32'(aux_signal_horiz_o), {12'h000, 10'h055, 10'h166});
    chk("aux_v", 32'(aux_signal_vert_o), {12'h000, 10'h377, 10'h288});
    $display("test windows done");
  endtask
  task automatic t_field();
    wr(ba(`DSST_FIELD_COUNT), 8'h0f);
    chk("fcount", 32'(display_field_count_o), 32'h0000_000f);
    chk("ftotal", 32'(fields_total), 32'h0000_0010);
    wr(ba(`DSST_FIELD_LEN_LO), 8'hc3);
    wr(ba(`DSST_FIELD_LEN_HI), 8'h05);
    chk("flen", 32'(display_field_length_o), 32'h0000_05c3);
    wr(ba(`DSST_HSWEEP_START), 8'hff);
    wr(ba(`DSST_HSWEEP_STOP), 8'h01);
    chk("hstart", 32'(horiz_sweep_pulse_start_o), 32'h0000_03fc);
    chk("hstop", 32'(horiz_sweep_pulse_stop_o), 32'h0000_0004);
    $display("test field and sweep done");
  endtask
  task automatic t_modes();
    int pos[6] = '{0, 1, 2, 4, 5, 6};
    logic [5:0] e;
    for (int k = 0; k < 6; k++) begin
      e = 6'h20 >> k;
      wr(ba(`DSST_SYNC_MODE), 8'h01 << pos[k]);
      chk("mode", 32'(sync_mode_o), 32'(e));
      chk("ie_pin", 32'(input_enable_pin_o), 32'(e[1]));
      chk("vreset", 32'(vert_reset_active), 32'(!e[5]));
    end
    rd(ba(`DSST_SYNC_MODE), 32'h0000_0040);
    $display("test sync modes done");
  endtask
  task automatic t_bad();
    wr(ba(10'h22f), 8'h5a, `DSST_RESP_SLVERR);
    wr(16'h1000 | ba(`DSST_SYNC_MODE), 8'h01, `DSST_RESP_SLVERR);
    chk("mode_kept", 32'(sync_mode_o), 32'h0000_0001);
    rd(ba(10'h232), `DSST_DATA_ZERO, `DSST_RESP_SLVERR);
    rd(16'h1000 | ba(`DSST_SYNC_MODE), `DSST_DATA_ZERO, `DSST_RESP_SLVERR);
    rd(ba(`DSST_STATUS), 32'h0001_0019);
    $display("test refused access done");
  endtask

  initial begin
    rst_i = 1'b1;
    s_axi_awvalid_i = 1'b0;
    s_axi_wvalid_i = 1'b0;
    s_axi_bready_i = 1'b0;
    s_axi_arvalid_i = 1'b0;
    s_axi_rready_i = 1'b0;
    s_axi_awaddr_i = 16'h0000;
    s_axi_araddr_i = 16'h0000;
    s_axi_wdata_i = `DSST_DATA_ZERO;
    s_axi_wstrb_i = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    do_reset();
    t_reset();
    t_vert();
    t_win();
    t_field();
    t_modes();
    t_bad();
    do_reset();
    t_reset();
    give_verdict();
  end
endmodule

// ### sim/dsst_display_sink.sv
// Deflection side view of the field setup and sync modes
`timescale 1ns/1ns
module dsst_display_sink
  import dsst_pkg::*;
(
  // From the block
  input wire logic [3:0]         field_count_i,
  input wire dsst_sync_mode_type mode_i,
  // Derived view
  output logic [4:0]             fields_total_o,
  output logic                   vert_reset_active_o
);
  // Stored count is one less, so sixteen fields fit in four bits
  assign fields_total_o = {1'b0, field_count_i} + 5'h01;
  assign vert_reset_active_o = !mode_i.vert_reset_disable;
endmodule
